// *** src/sar_frame_pkg.sv ***
// Purpose: Shared constants for the serial-framed SAR converter control
// Assumes: Host SCLK far slower than core_clk (at least 4 cycles per phase)
// Notes:   Falling-edge counts are 1-based within one chip select frame
// Behaviour
// - One frame spans select fall to rise
// - Select fall samples input, starts conversion
// - After conversion reconnect inputs, track input
// - Host serial clock paces steps and shifting
// - First zero at select fall, then zero, result
// - Data low after fourteen falling edges
// - Select rise ends frame, output three-state
// - Result twelve bits, straight binary coding
// - Codes 000, 800, FFF at scale points
// - First frame after power-up calibrates, output low
// - Power-up calibration needs sixteen falling edges
// - Short power-up frame leaves correction unchanged
// - Hidden correction store cleared at power-up
// - Stored correction applied to later conversions
// - Calibration disconnects both analog inputs
// - Normal calibration from fall 17 to 32
// - Under 32 falls leaves correction unchanged
// - Only a power cycle restores calibration state
package sar_frame_pkg;

  localparam int          ADC_BITS              = 12;
  localparam int          FIFO_DEPTH            = 4;

  // Transfer characteristic anchor codes and correction reset value
  localparam logic [11:0] NEG_FULL_SCALE_CODE   = 12'h000;
  localparam logic [11:0] MID_SCALE_CODE        = 12'h800;
  localparam logic [11:0] POS_FULL_SCALE_CODE   = 12'hFFF;
  localparam logic [11:0] OFFSET_RESET          = 12'h000;

  // Step and falling-edge counts
  localparam logic [3:0]  SAR_STEPS             = 4'hC;
  localparam logic [5:0]  FIRST_DATA_FALL       = 6'h02;
  localparam logic [5:0]  LAST_DATA_FALL        = 6'h0D;
  localparam logic [5:0]  DATA_END_FALL         = 6'h0E;
  localparam logic [5:0]  PWRUP_CAL_FALLS       = 6'h10;
  localparam logic [5:0]  NORMAL_CAL_START_FALL = 6'h11;
  localparam logic [5:0]  NORMAL_CAL_END_FALL   = 6'h20;
  localparam logic [5:0]  FALL_COUNT_MAX        = 6'h3F;

  // Converter phase, Gray along acquire, convert, trail, calibrate
  typedef enum logic [1:0] {
    ACQUIRE = 2'h0,
    CONVERT = 2'h1,
    TRAIL   = 2'h3,
    CALIB   = 2'h2
  } phase_t;

endpackage

// *** src/word_fifo.sv ***
// Purpose: Shifting FIFO for finished conversion words
// Assumes: Single clock, active-low asynchronous reset already synchronised
// Notes:   Head word and valid come straight from flip-flops
`timescale 1ns/1ps
module word_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rstN,
  // Fill side
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  inReady,
  // Drain side
  output logic                  outValid,
  output logic      [WIDTH-1:0] outData,
  input  wire logic             outReady
);

  logic [DEPTH:0]   slotValid;
  logic [WIDTH-1:0] slotData [DEPTH+1];
  logic             pop;
  logic             push;

  assign slotValid[DEPTH] = 1'b0;
  assign slotData[DEPTH]  = '0;
  assign pop              = slotValid[0] & outReady;
  // No simultaneous pop-and-fill when full: simpler, costs one cycle
  assign inReady          = ~slotValid[DEPTH-1];
  assign push             = inValid & inReady;
  assign outValid         = slotValid[0];
  assign outData          = slotData[0];

  for (genvar i = 0; i < DEPTH; i++) begin : g_slot
    logic shV;
    logic shPrev;
    logic [WIDTH-1:0] shD;
    assign shV    = pop ? slotValid[i+1] : slotValid[i];
    assign shD    = pop ? slotData[i+1] : slotData[i];
    if (i == 0) begin : g_head
      assign shPrev = 1'b1;
    end else begin : g_body
      assign shPrev = pop ? slotValid[i] : slotValid[i-1];
    end
    always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
        slotValid[i] <= 1'b0;
        slotData[i]  <= '0;
      end else if (push && !shV && shPrev) begin
        slotValid[i] <= 1'b1;
        slotData[i]  <= inData;
      end else begin
        slotValid[i] <= shV;
        slotData[i]  <= shD;
      end
    end
  end

endmodule

// *** src/sar_frame_ctrl.sv ***
// Purpose: Frame, successive-approximation and offset calibration control
// Assumes: csN, sclkPin and compAbove are asynchronous; nrst is power-on
// Notes:   Correction is applied to the trial level, so bits leave corrected
`timescale 1ns/1ps
module sar_frame_ctrl (
  // Clock and power-on reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // Serial link pins
  input  wire logic        csN,
  input  wire logic        sclkPin,
  output logic             sdo,
  output logic             sdoOeN,
  // Analog front end
  input  wire logic        compAbove,
  output logic      [11:0] dacCode,
  output logic             sampleHold,
  output logic             calActive,
  // Parallel word side
  output logic      [11:0] wordData,
  output logic             wordValid,
  input  wire logic        wordReady
);

  logic [1:0]                   rstSync;
  logic                         rstN;
  logic [2:0]                   csPipe;
  logic [2:0]                   sclkPipe;
  logic [1:0]                   compPipe;
  logic                         csFall;
  logic                         csRise;
  logic                         sclkFall;
  logic                         frameActive;
  logic                         firstFrame;
  logic [5:0]                   fallCount;
  logic [5:0]                   nextFall;
  sar_frame_pkg::phase_t        state;
  sar_frame_pkg::phase_t        next_state;
  logic [11:0]                  sarCode;
  logic [11:0]                  next_sar;
  logic [3:0]                   stepCount;
  logic [3:0]                   next_step;
  logic                         commit;
  logic                         convDone;
  logic [11:0]                  offsetStore;
  logic [11:0]                  pendWord;
  logic                         pendValid;
  logic                         fifoReady;

  // Reset release through two flops
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rstSync <= 2'h0;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstN = rstSync[1];

  // Pin synchronisers; stage 0 feeds only stage 1
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      csPipe   <= 3'h7;
      sclkPipe <= 3'h7;
      compPipe <= 2'h0;
    end else begin
      csPipe   <= {csPipe[1:0], csN};
      sclkPipe <= {sclkPipe[1:0], sclkPin};
      compPipe <= {compPipe[0], compAbove};
    end
  end

  assign csFall   = csPipe[2] & ~csPipe[1];
  assign csRise   = ~csPipe[2] & csPipe[1];
  assign sclkFall = sclkPipe[2] & ~sclkPipe[1] & frameActive & ~csRise;
  assign nextFall = (fallCount == sarframe_max()) ? fallCount : 6'(fallCount + 6'h01);

  function automatic logic [5:0] sarframe_max();
    return sar_frame_pkg::FALL_COUNT_MAX;
  endfunction

  // One decision: keep or drop the trial bit, then try the next one down
  function automatic logic [11:0] sar_step(input logic [11:0] code, input logic [3:0] steps,
                                           input logic above);
    logic [11:0] r;
    logic [3:0]  pos;
    r   = code;
    pos = 4'(4'hB - steps);
    r[pos] = above;
    if (pos != 4'h0) begin
      r[pos - 4'h1] = 1'b1;
    end
    return r;
  endfunction

  function automatic logic [11:0] sat_add(input logic [11:0] a, input logic [11:0] b);
    logic [12:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[12] ? sar_frame_pkg::POS_FULL_SCALE_CODE : s[11:0];
  endfunction

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      frameActive <= 1'b0;
      fallCount   <= 6'h00;
    end else if (csFall) begin
      frameActive <= 1'b1;
      fallCount   <= 6'h00;
    end else if (csRise) begin
      frameActive <= 1'b0;
    end else if (sclkFall) begin
      fallCount   <= nextFall;
    end
  end

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      firstFrame <= 1'b1;
    end else if (csRise) begin
      firstFrame <= 1'b0;
    end
  end

  always_comb begin
    next_state = state;
    next_sar   = sarCode;
    next_step  = stepCount;
    commit     = 1'b0;
    convDone   = 1'b0;
    if (csRise) begin
      next_state = sar_frame_pkg::ACQUIRE;
    end else if (csFall) begin
      next_sar   = sar_frame_pkg::MID_SCALE_CODE;
      next_step  = 4'h0;
      next_state = firstFrame ? sar_frame_pkg::CALIB : sar_frame_pkg::CONVERT;
    end else if (sclkFall) begin
      unique case (state)
        sar_frame_pkg::CONVERT: begin
          next_sar  = sar_step(sarCode, stepCount, compPipe[1]);
          next_step = 4'(stepCount + 4'h1);
          if (next_step == sar_frame_pkg::SAR_STEPS) begin
            next_state = sar_frame_pkg::TRAIL;
            convDone   = 1'b1;
          end
        end
        sar_frame_pkg::CALIB: begin
          if (stepCount != sar_frame_pkg::SAR_STEPS) begin
            next_sar  = sar_step(sarCode, stepCount, compPipe[1]);
            next_step = 4'(stepCount + 4'h1);
          end
          if (nextFall == (firstFrame ? sar_frame_pkg::PWRUP_CAL_FALLS
                                      : sar_frame_pkg::NORMAL_CAL_END_FALL)) begin
            commit     = 1'b1;
            next_state = sar_frame_pkg::TRAIL;
          end
        end
        sar_frame_pkg::TRAIL: begin
          if (!firstFrame && nextFall == sar_frame_pkg::NORMAL_CAL_START_FALL) begin
            next_state = sar_frame_pkg::CALIB;
            next_sar   = sar_frame_pkg::MID_SCALE_CODE;
            next_step  = 4'h0;
          end
        end
        sar_frame_pkg::ACQUIRE: begin
          next_state = state;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      state      <= sar_frame_pkg::ACQUIRE;
      sarCode    <= sar_frame_pkg::NEG_FULL_SCALE_CODE;
      stepCount  <= 4'h0;
      sampleHold <= 1'b0;
      calActive  <= 1'b0;
    end else begin
      state      <= next_state;
      sarCode    <= next_sar;
      stepCount  <= next_step;
      sampleHold <= (next_state == sar_frame_pkg::CONVERT) ||
                    (next_state == sar_frame_pkg::CALIB);
      calActive  <= next_state == sar_frame_pkg::CALIB;
    end
  end

  // only a completed calibration writes it
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      offsetStore <= sar_frame_pkg::OFFSET_RESET;
    end else if (commit) begin
      offsetStore <= sarCode;
    end
  end

  // corrected trial level
  // Calibration measures the raw offset, so it never sees the correction
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      dacCode <= sar_frame_pkg::MID_SCALE_CODE;
    end else if (state == sar_frame_pkg::CALIB) begin
      dacCode <= sarCode;
    end else begin
      dacCode <= sat_add(sarCode, offsetStore);
    end
  end

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      sdo    <= 1'b0;
      sdoOeN <= 1'b1;
    end else if (csRise) begin
      sdo    <= 1'b0;
      sdoOeN <= 1'b1;
    end else if (csFall) begin
      sdo    <= 1'b0;
      sdoOeN <= 1'b0;
    end else if (sclkFall) begin
      if (!firstFrame && nextFall >= sar_frame_pkg::FIRST_DATA_FALL &&
          nextFall <= sar_frame_pkg::LAST_DATA_FALL) begin
        sdo <= sarCode[4'(sar_frame_pkg::LAST_DATA_FALL - nextFall)];
      end else begin
        sdo <= 1'b0;
      end
    end
  end

  // finished word waits for room; a new one overwrites a stuck one
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      pendValid <= 1'b0;
      pendWord  <= sar_frame_pkg::NEG_FULL_SCALE_CODE;
    end else if (convDone) begin
      pendValid <= 1'b1;
      pendWord  <= next_sar;
    end else if (fifoReady) begin
      pendValid <= 1'b0;
    end
  end

  word_fifo #(
    .WIDTH (sar_frame_pkg::ADC_BITS),
    .DEPTH (sar_frame_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk      (core_clk),
    .rstN     (rstN),
    .inValid  (pendValid),
    .inData   (pendWord),
    .inReady  (fifoReady),
    .outValid (wordValid),
    .outData  (wordData),
    .outReady (wordReady)
  );

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstN);

  sequence s_open;
    csFall ##1 frameActive;
  endsequence

  sequence s_drive_low;
    !sdoOeN && !sdo;
  endsequence

  property p_frame_open;
    csFall |-> ##1 frameActive ##1 (frameActive || csRise || $past(csRise));
  endproperty
  a_frame_open: assert property (p_frame_open) else $error("frame not opened");

  property p_hold_on_fall;
    s_open |-> sampleHold;
  endproperty
  a_hold_on_fall: assert property (p_hold_on_fall) else $error("inputs not held");

  property p_reconnect;
    (sclkFall && state == sar_frame_pkg::CONVERT && stepCount == 4'hB)
      |=> !sampleHold && state == sar_frame_pkg::TRAIL;
  endproperty
  a_reconnect: assert property (p_reconnect) else $error("no reconnect");

  property p_first_bit;
    csFall |=> s_drive_low;
  endproperty
  a_first_bit: assert property (p_first_bit) else $error("no leading zero");

  property p_tail_low;
    (frameActive && fallCount >= sar_frame_pkg::DATA_END_FALL && !csRise) |=> !sdo;
  endproperty
  a_tail_low: assert property (p_tail_low) else $error("sdo high late");

  property p_tristate;
    csRise |=> sdoOeN [*2];
  endproperty
  a_tristate: assert property (p_tristate) else $error("sdo still driven");

  property p_cal_frame_low;
    (frameActive && firstFrame) |-> !sdo;
  endproperty
  a_cal_frame_low: assert property (p_cal_frame_low) else $error("sdo in cal frame");

  property p_short_pwrup;
    (csRise && firstFrame && fallCount < sar_frame_pkg::PWRUP_CAL_FALLS) |=> $stable(offsetStore);
  endproperty
  a_short_pwrup: assert property (p_short_pwrup) else $error("store changed early");

  property p_short_normal;
    (csRise && !firstFrame && fallCount < sar_frame_pkg::NORMAL_CAL_END_FALL)
      |=> $stable(offsetStore);
  endproperty
  a_short_normal: assert property (p_short_normal) else $error("store changed");

  property p_cal_isolated;
    calActive |-> sampleHold && frameActive;
  endproperty
  a_cal_isolated: assert property (p_cal_isolated) else $error("inputs on in cal");

  property p_msb_first;
    (sclkFall && !firstFrame && nextFall == sar_frame_pkg::FIRST_DATA_FALL)
      |=> sdo == $past(sarCode[11]);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("msb not first");

  property p_cal_start;
    (sclkFall && !firstFrame && state == sar_frame_pkg::TRAIL &&
     nextFall == sar_frame_pkg::NORMAL_CAL_START_FALL) |=> calActive ##1 calActive;
  endproperty
  a_cal_start: assert property (p_cal_start) else $error("cal not started");

endmodule

// *** verification/spi_host_model.sv ***
// Purpose: Behavioural host that frames the serial link of the converter
// Assumes: Link clock 125 ns, idle high and still between frames
// Notes:   Data sampled on each rising link edge; bit 0 sampled before first fall
`timescale 1ns/1ps
module spi_host_model (
  // Link pins
  output logic      csN,
  output logic      sclkPin,
  input  wire logic sdoLine,
  input  wire logic sdoOeN
);
  initial begin
    csN = 1'b1;
    sclkPin = 1'b1;
  end

  task automatic run_frame(input int nFalls, output logic [47:0] bits,
                           output logic [47:0] oeSeen);
    bits = '0;
    oeSeen = '0;
    // Called on a clock edge; step off it so pins never race the samplers
    #2;
    csN = 1'b0;
    #110;
    bits[0] = sdoLine;
    oeSeen[0] = sdoOeN;
    #15;
    for (int k = 1; k <= nFalls; k++) begin
      sclkPin = 1'b0;
      #62.5;
      sclkPin = 1'b1;
      bits[k] = sdoLine;
      oeSeen[k] = sdoOeN;
      #62.5;
    end
    csN = 1'b1;
    #500;
  endtask
endmodule

// *** verification/sar_frame_ctrl_bench.sv ***
// Purpose: Self-checking bench for the framed converter control
// Assumes: Comparator modelled as integer levels, offset added to the input
// Notes:   Random words and random drain stalls; fixed seed keeps runs repeatable
`timescale 1ns/1ps
module sar_frame_ctrl_bench;
  logic        core_clk;
  logic        nrst;
  logic        csN;
  logic        sclkPin;
  logic        sdo;
  logic        sdoOeN;
  logic        sdoLast;
  logic        sdoLine;
  logic        compAbove;
  logic [11:0] dacCode;
  logic        sampleHold;
  logic        calActive;
  logic [11:0] wordData;
  logic        wordValid;
  logic        wordReady;
  logic        stall;
  logic [11:0] vin;
  logic [11:0] devOff;
  logic [12:0] ana;
  logic [11:0] expQ[$];
  logic [47:0] bits;
  logic [47:0] oeSeen;
  int          seed;
  int          nErrors;
  int          numChecks;

  sar_frame_ctrl dut_u (
    .core_clk   (core_clk),
    .nrst       (nrst),
    .csN        (csN),
    .sclkPin    (sclkPin),
    .sdo        (sdo),
    .sdoOeN     (sdoOeN),
    .compAbove  (compAbove),
    .dacCode    (dacCode),
    .sampleHold (sampleHold),
    .calActive  (calActive),
    .wordData   (wordData),
    .wordValid  (wordValid),
    .wordReady  (wordReady)
  );

  spi_host_model host_u (
    .csN     (csN),
    .sclkPin (sclkPin),
    .sdoLine (sdoLine),
    .sdoOeN  (sdoOeN)
  );

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Released line shows the inverse, never a stale zero
  assign sdoLine = sdoOeN ? ~sdoLast : sdo;
  // Inputs cut off during calibration, so only the offset is seen
  assign ana = calActive ? {1'b0, devOff} : {1'b0, vin} + {1'b0, devOff};

  always @(posedge core_clk) begin
    if (sdoOeN === 1'b0) begin
      sdoLast <= sdo;
    end
    compAbove <= (ana >= {1'b0, dacCode});
    wordReady <= stall ? 1'b0 : 1'($random(seed));
    if (wordValid === 1'b1 && wordReady === 1'b1) begin
      if (expQ.size() == 0) begin
        check("unexpected word", 48'h0, 48'h1);
      end else begin
        check("word", {36'h0, expQ.pop_front()}, {36'h0, wordData});
      end
    end
  end

  task automatic check(input string what, input logic [47:0] exp, input logic [47:0] got);
    numChecks++;
    if (got !== exp) begin
      nErrors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [47:0] exp_bits(input logic [11:0] code, input int n,
                                           input logic pwr);
    logic [47:0] e;
    e = '0;
    for (int k = 2; k <= 13; k++) begin
      if (!pwr && k <= n) begin
        e[k] = code[13-k];
      end
    end
    return e;
  endfunction

  task automatic frame(input int n, input logic [11:0] v, input logic pwr,
                       input logic [11:0] code);
    vin = v;
    if (!pwr && n >= 12) begin
      expQ.push_back(code);
    end
    @(posedge core_clk);
    fork
      host_u.run_frame(n, bits, oeSeen);
      begin
        #100;
        check("held, calibrating", {46'h0, 1'b1, pwr}, {46'h0, sampleHold, calActive});
      end
    join
    check("sdo bits", exp_bits(code, n, pwr), bits);
    check("sdo enable in frame", 48'h0, oeSeen);
    check("sdo enable idle", 48'h1, {47'h0, sdoOeN});
    check("tracking after frame", 48'h0, {46'h0, sampleHold, calActive});
  endtask

  task automatic drain();
    stall = 1'b0;
    for (int i = 0; i < 400 && expQ.size() != 0; i++) begin
      @(posedge core_clk);
    end
    check("words left", 48'h0, 48'(expQ.size()));
    repeat (3) @(posedge core_clk);
    check("fifo empty", 48'h0, {47'h0, wordValid});
  endtask

  task automatic do_reset();
    @(posedge core_clk);
    nrst <= 1'b0;
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (5) @(posedge core_clk);
  endtask

  task automatic final_report();
    if (nErrors == 0 && numChecks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    #400000;
    nErrors++;
    final_report();
  end

  initial begin
    logic [11:0] v;
    int          n;
    seed = 32'he748;
    nErrors = 0;
    numChecks = 0;
    nrst = 1'b0;
    vin = 12'h000;
    devOff = 12'h005;
    stall = 1'b0;
    wordReady = 1'b0;
    compAbove = 1'b0;
    sdoLast = 1'b0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (5) @(posedge core_clk);
    frame(10, 12'h100, 1'b1, 12'h000);
    devOff = 12'h000;
    frame(14, 12'h000, 1'b0, 12'h000);
    frame(14, 12'h800, 1'b0, 12'h800);
    frame(20, 12'hFFF, 1'b0, 12'hFFF);
    devOff = 12'h005;
    frame(31, 12'h100, 1'b0, 12'h105);
    frame(14, 12'h100, 1'b0, 12'h105);
    frame(32, 12'h200, 1'b0, 12'h205);
    // Downstream stalled: four in the FIFO, one pending
    stall = 1'b1;
    repeat (5) begin
      v = 12'($unsigned($random(seed))) % 12'hFFA;
      frame(14, v, 1'b0, v);
    end
    repeat (20) @(posedge core_clk);
    check("stalled words", 48'h5, 48'(expQ.size()));
    drain();
    repeat (8) begin
      v = 12'($unsigned($random(seed))) % 12'hFFA;
      n = 12 + int'($unsigned($random(seed)) % 21);
      frame(n, v, 1'b0, v);
    end
    drain();
    do_reset();
    devOff = 12'h009;
    frame(16, 12'h300, 1'b1, 12'h000);
    frame(14, 12'h300, 1'b0, 12'h300);
    drain();
    do_reset();
    frame(12, 12'h300, 1'b1, 12'h000);
    frame(14, 12'h300, 1'b0, 12'h309);
    drain();
    final_report();
  end
endmodule
